/* src/psb_core.sv */
// Purpose: pipelined burst SRAM core, command decode to data lines
// Assumes: synchronous inputs except sleep and output enable
// Notes:   data lines are split into input, output and enable
`timescale 1ns/100ps
`include "psb_consts.svh"

module psb_core
   import psb_pkg::*;
#(
   parameter int AW        = `PSB_ADDR_W,
   parameter int LANES     = `PSB_LANES,
   parameter int SLEEP_CYC = `PSB_SLEEP_CYC
) (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          nrst,
   // command inputs
   input  wire logic                          clock_qualifier_n,
   input  wire logic                          chip_select_1_n,
   input  wire logic                          chip_select_2,
   input  wire logic                          chip_select_3_n,
   input  wire logic                          advance_or_load,
   input  wire logic                          write_enable_n,
   input  wire logic [AW-1:0]                 addr,
   input  wire logic [LANES-1:0]              lane_write_selects_n,
   // asynchronous controls and strap
   input  wire logic                          output_enable_n,
   input  wire logic                          sleep_request,
   input  wire logic                          burst_order,
   // data and parity lines
   input  wire logic [LANES*`PSB_BYTE_W-1:0]  data_lines_in,
   input  wire logic [LANES-1:0]              parity_lines_in,
   output      logic [LANES*`PSB_BYTE_W-1:0]  data_lines_out,
   output      logic [LANES-1:0]              parity_lines_out,
   output      logic                          data_lines_oe,
   // status
   output      logic                          sleep_active
);

   localparam int WORD_W = LANES * `PSB_LANE_W;
   localparam int BW     = `PSB_BURST_W;

   // ----------------------------------------------------------
   // declarations
   // ----------------------------------------------------------
   logic [SLEEP_CYC-1:0] sleep_sync_q;
   logic                 sleep_q;
   logic                 go;
   logic                 sel;
   logic                 load;
   psb_cmd_t             st1_q;
   psb_cmd_t             st1_d;
   psb_cmd_t             st2_q;
   psb_kind_t            burst_kind_q;
   logic [AW-1:BW]       burst_hi_q;
   logic [BW-1:0]        burst_base_q;
   logic [BW-1:0]        burst_cnt_q;
   logic [BW-1:0]        burst_cnt_d;
   logic                 burst_ilv_q;
   logic [BW-1:0]        beat_lo;
   logic                 drive_q;
   logic                 mem_we;
   logic                 mem_re;
   logic [WORD_W-1:0]    wr_word;
   logic [WORD_W-1:0]    rd_word_q;

   // ----------------------------------------------------------
   // sleep request synchroniser
   // ----------------------------------------------------------
   // the shift depth sets both entry and exit latency
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sleep_sync_q <= '0;
      end else begin
         sleep_sync_q <= {sleep_sync_q[SLEEP_CYC-2:0], sleep_request};
      end
   end

   assign sleep_q      = sleep_sync_q[SLEEP_CYC-1];
   assign sleep_active = sleep_q;

   // ----------------------------------------------------------
   // command decode
   // ----------------------------------------------------------
   assign go   = !clock_qualifier_n && !sleep_q;
   assign sel  = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
   assign load = !advance_or_load;

   assign burst_cnt_d = BW'(burst_cnt_q + `PSB_CNT_STEP);

   // next low address pair of a burst beat
   always_comb begin
      if (burst_ilv_q) begin
         beat_lo = burst_base_q ^ burst_cnt_d;
      end else begin
         beat_lo = BW'(burst_base_q + burst_cnt_d);
      end
   end

   always_comb begin
      st1_d.kind    = PSB_IDLE;
      st1_d.addr    = addr;
      st1_d.lanes_n = lane_write_selects_n;
      if (load) begin
         if (sel && write_enable_n) begin
            st1_d.kind = PSB_READ;
         end else if (sel) begin
            st1_d.kind = PSB_WRITE;
         end
      end else begin
         // selects and write strobe are not looked at here
         st1_d.kind = burst_kind_q;
         st1_d.addr = {burst_hi_q, beat_lo};
      end
   end

   // ----------------------------------------------------------
   // burst state
   // ----------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         burst_kind_q <= PSB_IDLE;
         burst_hi_q   <= '0;
         burst_base_q <= '0;
         burst_cnt_q  <= `PSB_CNT_RST;
         burst_ilv_q  <= `PSB_ORDER_ILV;
      end else if (sleep_q) begin
         burst_kind_q <= PSB_IDLE;
      end else if (go) begin
         if (load) begin
            burst_kind_q <= st1_d.kind;
            burst_hi_q   <= addr[AW-1:BW];
            burst_base_q <= addr[BW-1:0];
            burst_cnt_q  <= `PSB_CNT_RST;
            burst_ilv_q  <= burst_order;
         end else begin
            burst_cnt_q  <= burst_cnt_d;
         end
      end
   end

   // ----------------------------------------------------------
   // command pipeline
   // ----------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st1_q.kind    <= PSB_IDLE;
         st1_q.addr    <= '0;
         st1_q.lanes_n <= `PSB_LANES_OFF;
      end else if (sleep_q) begin
         st1_q.kind    <= PSB_IDLE;
      end else if (go) begin
         st1_q         <= st1_d;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st2_q.kind    <= PSB_IDLE;
         st2_q.addr    <= '0;
         st2_q.lanes_n <= `PSB_LANES_OFF;
      end else if (sleep_q) begin
         st2_q.kind    <= PSB_IDLE;
      end else if (go) begin
         st2_q         <= st1_q;
      end
   end

   // ----------------------------------------------------------
   // memory access
   // ----------------------------------------------------------
   always_comb begin
      wr_word = '0;
      for (int i = 0; i < LANES; i++) begin
         wr_word[i*`PSB_LANE_W +: `PSB_LANE_W] =
            {parity_lines_in[i], data_lines_in[i*`PSB_BYTE_W +: `PSB_BYTE_W]};
      end
   end

   assign mem_we = go && st2_q.kind == PSB_WRITE;
   assign mem_re = go && st1_q.kind == PSB_READ;

   psb_mem #(
      .AW     (AW),
      .LANES  (LANES),
      .LANE_W (`PSB_LANE_W)
   ) u_mem (
      .clk      (clk),
      .nrst     (nrst),
      .we       (mem_we),
      .waddr    (st2_q.addr),
      .wlanes_n (st2_q.lanes_n),
      .wdata    (wr_word),
      .re       (mem_re),
      .raddr    (st1_q.addr),
      .rdata_q  (rd_word_q)
   );

   // ----------------------------------------------------------
   // output drive
   // ----------------------------------------------------------
   // writes, deselects and idle beats all clear the drive flag
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drive_q <= 1'b0;
      end else if (sleep_q) begin
         drive_q <= 1'b0;
      end else if (go) begin
         drive_q <= st1_q.kind == PSB_READ;
      end
   end

   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         data_lines_out[i*`PSB_BYTE_W +: `PSB_BYTE_W] =
            rd_word_q[i*`PSB_LANE_W +: `PSB_BYTE_W];
         parity_lines_out[i] = rd_word_q[i*`PSB_LANE_W + `PSB_BYTE_W];
      end
   end

   // enable gated without sampling; dummy reads stay off the bus
   assign data_lines_oe = drive_q && !output_enable_n && !sleep_q;

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   read_drive_a: assert property (
      (go && load && sel && write_enable_n) ##1 go |=> drive_q
   ) else $error("read not driven after second edge");

   deselect_tri_a: assert property (
      (go && load && !sel) ##1 go |=> !data_lines_oe
   ) else $error("outputs not tri-stated after deselect");

   write_tri_a: assert property (
      (go && load && sel && !write_enable_n) ##1 go |=> !data_lines_oe
   ) else $error("outputs driven during write data phase");

   write_capture_a: assert property (
      (go && load && sel && !write_enable_n) ##1 go ##1 go |-> mem_we
   ) else $error("write data not captured at second edge");

   linear_order_a: assert property (
      (go && !load && burst_kind_q != PSB_IDLE && !burst_ilv_q)
      |=> st1_q.addr[BW-1:0] == BW'($past(st1_q.addr[BW-1:0]) + `PSB_CNT_STEP)
   ) else $error("linear burst address wrong");

   ilv_order_a: assert property (
      (go && !load && burst_kind_q != PSB_IDLE && burst_ilv_q)
      |=> st1_q.addr[BW-1:0] == (burst_base_q ^ burst_cnt_q)
   ) else $error("interleaved burst address wrong");

   burst_type_a: assert property (
      (go && !load) |=> st1_q.kind == $past(burst_kind_q)
   ) else $error("burst access type changed");

   stall_hold_a: assert property (
      (clock_qualifier_n && !sleep_q) |=> $stable(st1_q) && $stable(burst_cnt_q)
         && $stable(drive_q)
   ) else $error("state changed on ignored edge");

   oe_async_a: assert property (
      data_lines_oe |-> !output_enable_n && drive_q
   ) else $error("drive not gated by output enable");

   sleep_enter_a: assert property (
      sleep_request [*2] |=> sleep_q
   ) else $error("sleep not entered in two cycles");

   sleep_tri_a: assert property (
      sleep_q |-> !data_lines_oe && !mem_we
   ) else $error("bus or array active in sleep");

endmodule

/* shared/psb_consts.svh */
// Purpose: constants of the pipelined burst SRAM core
// Assumes: one rising-edge clock, 36-bit word in four 9-bit lanes
// Notes:   sizes, reset values and timing counts live here; the memory defaults and the host model repeat the sizes
//
// What this block does
// - read starts: qualified, selected, write high, load
// - read data driven after next edge, enable low
// - new command accepted every clock, back to back
// - deselect tri-states outputs after next clock rise
// - two-bit burst counter, four beats, wraps around
// - burst order strap: low linear, high interleaved
// - interleaved beat address is start XOR count
// - linear beat address is start plus count
// - advance steps counter, ignores selects and write
// - access type latched at burst start, kept
// - write starts: qualified, selected, write low
// - edge after write command tri-states data lines
// - write data captured second edge after command
// - only lanes with low select are written
// - sleep keeps contents, two cycles in and out
// - read with output enable high is dummy
// - any write cycle tri-states all data lines
// - qualifier high: edge ignored, state held
// - powers up deselected, data lines tri-stated
// - output enable acts asynchronously, masked on writes
// - floating strap selects interleaved order; no pull here, each load copies burst_order as driven
`ifndef PSB_CONSTS_SVH
`define PSB_CONSTS_SVH

// sizes
`define PSB_ADDR_W     17
`define PSB_LANES      4
`define PSB_LANE_W     9
`define PSB_BYTE_W     8
`define PSB_BURST_W    2

// sleep entry and exit time, in clock cycles
`define PSB_SLEEP_CYC  2

// reset, idle and counter step values
`define PSB_LANES_OFF  4'hF
`define PSB_CNT_RST    2'h0
`define PSB_CNT_STEP   2'h1
`define PSB_ORDER_ILV  1'b1

`endif

/* shared/psb_pkg.sv */
// Purpose: types shared by the SRAM core files
// Assumes: psb_consts.svh on the include path
// Notes:   one command word travels down the pipeline
`include "psb_consts.svh"

package psb_pkg;

   typedef enum logic [1:0] {
      PSB_IDLE,
      PSB_READ,
      PSB_WRITE
   } psb_kind_t;

   typedef struct packed {
      psb_kind_t                  kind;
      logic [`PSB_ADDR_W-1:0]     addr;
      logic [`PSB_LANES-1:0]      lanes_n;
   } psb_cmd_t;

endpackage

/* src/psb_mem.sv */
// Purpose: lane-writable memory array with registered read data
// Assumes: write and read may hit one address in one cycle
// Notes:   such a read returns the new lanes merged over the old word
`timescale 1ns/100ps

module psb_mem #(
   parameter int AW     = 17,
   parameter int LANES  = 4,
   parameter int LANE_W = 9
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    nrst,
   // write port
   input  wire logic                    we,
   input  wire logic [AW-1:0]           waddr,
   input  wire logic [LANES-1:0]        wlanes_n,
   input  wire logic [LANES*LANE_W-1:0] wdata,
   // read port
   input  wire logic                    re,
   input  wire logic [AW-1:0]           raddr,
   output      logic [LANES*LANE_W-1:0] rdata_q
);

   logic [LANES*LANE_W-1:0] mem_q [2**AW];
   logic [LANES*LANE_W-1:0] rdata_d;

   // ----------------------------------------------------------
   // write with lane selects
   // ----------------------------------------------------------
   always_ff @(posedge clk) begin
      for (int i = 0; i < LANES; i++) begin
         if (we && !wlanes_n[i]) begin
            mem_q[waddr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
         end
      end
   end

   // ----------------------------------------------------------
   // read with write forwarding
   // ----------------------------------------------------------
   always_comb begin
      rdata_d = mem_q[raddr];
      for (int i = 0; i < LANES; i++) begin
         if (we && !wlanes_n[i] && waddr == raddr) begin
            rdata_d[i*LANE_W +: LANE_W] = wdata[i*LANE_W +: LANE_W];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else if (re) begin
         rdata_q <= rdata_d;
      end
   end

endmodule

/* dv/psb_host_model.sv */
// Purpose: host controller model that drives the SRAM core bus
// Assumes: bench calls cmd once per clock, just after the rising edge
// Notes:   write data follows its command by two counted edges
`timescale 1ns/100ps

module psb_host_model (
   // clock
   input  wire logic        clk,
   // device outputs
   input  wire logic [31:0] data_lines_out,
   input  wire logic [3:0]  parity_lines_out,
   input  wire logic        data_lines_oe,
   // device inputs
   output      logic        clock_qualifier_n,
   output      logic        chip_select_1_n,
   output      logic        chip_select_2,
   output      logic        chip_select_3_n,
   output      logic        advance_or_load,
   output      logic        write_enable_n,
   output      logic [16:0] addr,
   output      logic [3:0]  lane_write_selects_n,
   output      logic        output_enable_n,
   output      logic        sleep_request,
   output      logic        burst_order,
   output      logic [31:0] data_lines_in,
   output      logic [3:0]  parity_lines_in
);
   logic [35:0] last_q;
   logic [35:0] wd_q;
   logic [35:0] hd_q;
   logic [35:0] nxt;
   logic        w1_q = 1'b0;
   logic        hdrv_q = 1'b0;
   logic        wr_burst = 1'b0;
   logic        wbeat = 1'b0;

   initial begin
      {clock_qualifier_n, chip_select_1_n, chip_select_3_n} = 3'h7;
      {chip_select_2, advance_or_load, write_enable_n} = 3'h1;
      addr = 17'h0;
      lane_write_selects_n = 4'hF;
      output_enable_n = 1'b0;
      sleep_request = 1'b0;
      burst_order = 1'b1;
      nxt = 36'h0;
   end

   // -------------------------------------------------------------
   // shared bus: device, host, else inverse of last level
   // -------------------------------------------------------------
   always_comb begin
      if (data_lines_oe) begin
         {parity_lines_in, data_lines_in} = {parity_lines_out, data_lines_out};
      end else if (hdrv_q) begin
         {parity_lines_in, data_lines_in} = hd_q;
      end else begin
         {parity_lines_in, data_lines_in} = ~last_q;
      end
   end

   always @(posedge clk) begin
      last_q <= {parity_lines_in, data_lines_in};
      if (!clock_qualifier_n) begin
         w1_q   <= wbeat;
         wd_q   <= nxt;
         hdrv_q <= w1_q;
         hd_q   <= wd_q;
      end
   end

   // one command per clock; lane selects given on every beat
   task automatic cmd(input logic adv, input logic sel, input logic we_n,
                      input logic [16:0] a, input logic [3:0] ln, input logic [35:0] d);
      clock_qualifier_n = 1'b0;
      advance_or_load = adv;
      chip_select_1_n = !sel;
      chip_select_2 = sel;
      chip_select_3_n = !sel;
      write_enable_n = we_n;
      addr = a;
      lane_write_selects_n = ln;
      nxt = d;
      if (!adv) begin
         wr_burst = sel && !we_n;
      end
      wbeat = wr_burst;
      // hold the command through the edge that takes it
      @(posedge clk);
      #2;
   endtask

endmodule

/* dv/psb_core_tb.sv */
// Purpose: self-checking bench for the pipelined burst SRAM core
// Assumes: host model owns every command and data input
// Notes:   words at addresses 8 to 11 hold a pattern of the address
`timescale 1ns/100ps

module pipelined_sram_burst_access_tb_top;
   logic        clk;
   logic        nrst;
   wire  logic  qn, cs1_n, cs2, cs3_n, adv, we_n, oe_n, slp, ord, oe, sa;
   wire  logic [16:0] a;
   wire  logic [3:0]  ln, pin, pout;
   wire  logic [31:0] din, dout;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          cycles = 0;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   psb_core psb_core_i (.clk(clk), .nrst(nrst), .clock_qualifier_n(qn),
      .chip_select_1_n(cs1_n), .chip_select_2(cs2), .chip_select_3_n(cs3_n),
      .advance_or_load(adv), .write_enable_n(we_n), .addr(a),
      .lane_write_selects_n(ln), .output_enable_n(oe_n), .sleep_request(slp),
      .burst_order(ord), .data_lines_in(din), .parity_lines_in(pin),
      .data_lines_out(dout), .parity_lines_out(pout), .data_lines_oe(oe),
      .sleep_active(sa));

   psb_host_model psb_host_model_i (.clk(clk), .data_lines_out(dout),
      .parity_lines_out(pout), .data_lines_oe(oe), .clock_qualifier_n(qn),
      .chip_select_1_n(cs1_n), .chip_select_2(cs2), .chip_select_3_n(cs3_n),
      .advance_or_load(adv), .write_enable_n(we_n), .addr(a),
      .lane_write_selects_n(ln), .output_enable_n(oe_n), .sleep_request(slp),
      .burst_order(ord), .data_lines_in(din), .parity_lines_in(pin));

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic [35:0] pat(input logic [16:0] x);
      return {x[3:0], 16'hC3A5, x[15:0]};
   endfunction

   task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic op(input logic ad, input logic sel, input logic w, input logic [16:0] x,
                     input logic [3:0] l, input logic [35:0] d);
      psb_host_model_i.cmd(ad, sel, w, x, l, d);
   endtask

   task automatic rd(input logic [16:0] x);
      op(1'b0, 1'b1, 1'b1, x, 4'hF, 36'h0);
   endtask

   task automatic wr(input logic [16:0] x, input logic [3:0] l, input logic [35:0] d);
      op(1'b0, 1'b1, 1'b0, x, l, d);
   endtask

   task automatic desel;
      op(1'b0, 1'b0, 1'b1, 17'h0, 4'hF, 36'h0);
   endtask

   task automatic give_verdict;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_writes;
      for (int i = 8; i < 12; i++) begin
         wr(17'(i), 4'h0, pat(17'(i)));
      end
      rd(17'h8);
      rd(17'h9);
      chk({oe, pout, dout}, {1'b1, pat(17'h8)});
      wr(17'hA, 4'h0, pat(17'hA));
      chk({oe, pout, dout}, {1'b1, pat(17'h9)});
      desel;
      chk({36'h0, oe}, 37'h0);
      desel;
   endtask

   task automatic t_burst(input logic o, input logic [1:0] s);
      logic [1:0] b;
      psb_host_model_i.burst_order = o;
      rd({15'h2, s});
      for (int n = 0; n < 4; n++) begin
         b = o ? s ^ 2'(n) : s + 2'(n);
         if (n < 3) begin
            op(1'b1, 1'b0, 1'b0, 17'h0, 4'h0, 36'h0);
         end else begin
            desel;
         end
         chk({oe, pout, dout}, {1'b1, pat({15'h2, b})});
      end
      desel;
   endtask

   task automatic t_lanes;
      wr(17'h8, 4'hA, ~pat(17'h8));
      desel;
      desel;
      rd(17'h8);
      desel;
      chk({oe, pout, dout}, {1'b1, (~pat(17'h8) & 36'h500FF00FF) |
                                   (pat(17'h8) & ~36'h500FF00FF)});
   endtask

   task automatic t_wburst;
      psb_host_model_i.burst_order = 1'b0;
      wr(17'hC, 4'h0, pat(17'hC));
      for (int n = 13; n < 16; n++) begin
         op(1'b1, 1'b0, 1'b1, 17'h0, 4'h0, pat(17'(n)));
      end
      wr(17'hC, 4'hF, ~pat(17'hC));
      op(1'b1, 1'b0, 1'b1, 17'h0, 4'h0, ~pat(17'hD));
      desel;
      op(1'b1, 1'b1, 1'b1, 17'hC, 4'hF, 36'h0);
      desel;
      chk({36'h0, oe}, 37'h0);
      rd(17'hC);
      for (int n = 13; n < 17; n++) begin
         if (n < 16) begin
            rd(17'(n));
         end else begin
            desel;
         end
         chk({oe, pout, dout}, {1'b1, n == 14 ? ~pat(17'hD) : pat(17'(n - 1))});
      end
   endtask

   task automatic t_oe;
      psb_host_model_i.output_enable_n = 1'b1;
      rd(17'h9);
      desel;
      chk({36'h0, oe}, 37'h0);
      psb_host_model_i.output_enable_n = 1'b0;
      #1;
      chk({oe, pout, dout}, {1'b1, pat(17'h9)});
      @(posedge clk);
      #2;
      chk({36'h0, oe}, 37'h0);
   endtask

   task automatic t_stall;
      rd(17'hA);
      psb_host_model_i.clock_qualifier_n = 1'b1;
      @(posedge clk);
      #2;
      chk({36'h0, oe}, 37'h0);
      desel;
      chk({oe, pout, dout}, {1'b1, pat(17'hA)});
      desel;
      chk({36'h0, oe}, 37'h0);
   endtask

   task automatic t_sleep;
      desel;
      psb_host_model_i.sleep_request = 1'b1;
      for (int n = 0; n < 4; n++) begin
         @(posedge clk);
         #2;
         chk({36'h0, sa}, {36'h0, n == 1 || n == 2});
         if (n == 1) begin
            psb_host_model_i.sleep_request = 1'b0;
         end
      end
      desel;
      desel;
      rd(17'hB);
      desel;
      chk({oe, pout, dout}, {1'b1, pat(17'hB)});
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         error_cnt++;
         give_verdict;
      end
   end

   initial begin
      nrst = 1'b0;
      repeat (4) @(posedge clk);
      #2;
      nrst = 1'b1;
      chk({36'h0, oe}, 37'h0);
      t_writes;
      t_burst(1'b0, 2'h1);
      t_burst(1'b1, 2'h1);
      t_burst(1'b0, 2'h3);
      t_lanes;
      t_wburst;
      t_oe;
      t_stall;
      t_sleep;
      give_verdict;
   end

endmodule
